/* design/imrss_ctrl.v */
// two-wire controller: master receive with 8/9 wait, slave send
`timescale 1ns/1ps
`include "imrss_defines.vh"
module imrss_ctrl (
    input wire mclk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire scl_i,
    output wire scl_o,
    output wire scl_oe_o,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    input wire start_request_i,
    input wire stop_request_i,
    input wire shift_wr_i,
    input wire [7:0] shift_wdata_i,
    input wire wait_release_i,
    input wire wait_timing_select_i,
    input wire ack_enable_i,
    input wire fast_mode_i,
    input wire [6:0] own_address_i,
    output wire [7:0] shift_rdata_o,
    output wire master_status_o,
    output wire ack_detected_o,
    output wire transmit_receive_select_o,
    output wire wait_state_o,
    output wire bus_busy_o,
    output wire transfer_interrupt_o,
    output wire [3:0] int_cause_o,
    output wire rx_valid_o,
    output wire [7:0] rx_data_o,
    input wire rx_ready_i
);
    // ns figure to terminal count, rounded up, never below one cycle
    function [9:0] tcyc;
        input fast;
        input [31:0] std_ns;
        input [31:0] fast_ns;
        reg [31:0] c;
        begin
            c = ((fast ? fast_ns : std_ns) + `IMRSS_CLK_NS - 1) / `IMRSS_CLK_NS;
            if (c == 32'h0) begin
                c = 32'h1;
            end
            tcyc = c[9:0] - 10'h001;
        end
    endfunction

    wire scl_lvl; // synchronised bus clock
    wire scl_rise;
    wire scl_fall;
    wire sda_lvl; // synchronised bus data
    wire sda_rise;
    wire sda_fall;
    wire fifo_in_ready; // back-pressure from the rx fifo

    reg [3:0] ms_reg; // master fsm, one-hot
    reg [9:0] tmr_reg; // phase timer
    reg gen_low_reg; // master clock generator low phase
    reg hold_reg; // wait: clock held low
    reg stop_arm_reg; // stop: data low already set up
    reg busy_reg; // between start and stop
    reg mst_reg; // master status
    reg sl_act_reg; // slave still taking part
    reg addr_phase_reg; // first byte after start
    reg match_reg; // slave address matched
    reg dir_rd_reg; // direction bit of address
    reg slave_tx_reg; // slave is sending
    reg [3:0] bitcnt_reg; // clock rises seen in byte
    reg ack_slot_reg; // between 8th and 9th fall
    reg drv_bit_reg; // pull data low for current bit
    reg [7:0] shift_reg;
    reg ack_det_reg;
    reg push_reg; // byte waiting for fifo room
    reg pushed_reg; // this byte already queued
    reg irq_reg;
    reg [3:0] cause_reg;
    reg sda_oe_reg;
    reg scl_oe_reg;
    reg tx_reg; // registered transmit/receive status
    reg sda_oe_next;

    wire start_det = sda_fall & scl_lvl;
    wire stop_det = sda_rise & scl_lvl;
    wire [9:0] thd_cyc = tcyc(fast_mode_i, `IMRSS_T_HD_STA_STD_NS, `IMRSS_T_HD_STA_FAST_NS);
    wire [9:0] tsu_cyc = tcyc(fast_mode_i, `IMRSS_T_SU_STO_STD_NS, `IMRSS_T_SU_STO_FAST_NS);
    wire [9:0] tlow_cyc = tcyc(fast_mode_i, `IMRSS_T_LOW_STD_NS, `IMRSS_T_LOW_FAST_NS);
    wire [9:0] thi_cyc = tcyc(fast_mode_i, `IMRSS_T_HIGH_STD_NS, `IMRSS_T_HIGH_FAST_NS);
    wire engine_on = busy_reg & (mst_reg | sl_act_reg);
    // master sends the address, then sends only if it asked to write
    wire tx_role = addr_phase_reg ? mst_reg : (mst_reg ? ~dir_rd_reg : slave_tx_reg);
    wire ack_drive = mst_reg ? (~addr_phase_reg & dir_rd_reg & ack_enable_i)
                             : (addr_phase_reg & match_reg);

    imrss_pin_sync u_scl_sync (
        .clk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .pin_i(scl_i),
        .lvl_o(scl_lvl),
        .rise_o(scl_rise),
        .fall_o(scl_fall)
    );

    imrss_pin_sync u_sda_sync (
        .clk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .pin_i(sda_i),
        .lvl_o(sda_lvl),
        .rise_o(sda_rise),
        .fall_o(sda_fall)
    );

    // received bytes queue here; a full queue keeps the wait in force
    imrss_fifo #(
        .WIDTH(8),
        .DEPTH(`IMRSS_FIFO_DEPTH),
        .AW(`IMRSS_FIFO_AW)
    ) u_rx_fifo (
        .clk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .in_valid_i(push_reg),
        .in_data_i(shift_reg),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(rx_valid_o),
        .out_data_o(rx_data_o),
        .out_ready_i(rx_ready_i)
    );

    // data pin drive: start/stop force, bit data, or acknowledge slot
    always @* begin
        sda_oe_next = 1'b0;
        if (ms_reg == `IMRSS_M_START || ms_reg == `IMRSS_M_STOP) begin
            sda_oe_next = 1'b1;
        end else if (busy_reg) begin
            if (ack_slot_reg) begin
                sda_oe_next = ack_drive; // low is ACK, released is NACK
            end else begin
                sda_oe_next = tx_role & drv_bit_reg;
            end
        end
    end

    // whole controller state; later assignments in the block win
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ms_reg <= `IMRSS_M_IDLE;
            tmr_reg <= 10'h000;
            gen_low_reg <= 1'b0;
            hold_reg <= 1'b0;
            stop_arm_reg <= 1'b0;
            busy_reg <= 1'b0;
            mst_reg <= 1'b0;
            sl_act_reg <= 1'b0;
            addr_phase_reg <= 1'b0;
            match_reg <= 1'b0;
            dir_rd_reg <= 1'b0;
            slave_tx_reg <= 1'b0;
            bitcnt_reg <= 4'h0;
            ack_slot_reg <= 1'b0;
            drv_bit_reg <= 1'b0;
            shift_reg <= 8'h00;
            ack_det_reg <= 1'b0;
            push_reg <= 1'b0;
            pushed_reg <= 1'b0;
            irq_reg <= 1'b0;
            cause_reg <= `IMRSS_EV_NONE;
            sda_oe_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            tx_reg <= 1'b0;
        end else if (ce_i) begin
            irq_reg <= 1'b0;
            sda_oe_reg <= sda_oe_next;
            // clock low while waiting or in the generator low phase
            scl_oe_reg <= hold_reg | ((ms_reg == `IMRSS_M_RUN) & gen_low_reg);
            tx_reg <= busy_reg & tx_role;
            if (push_reg && fifo_in_ready) begin
                push_reg <= 1'b0;
            end
            // software loads the shift register; first bit goes out at once
            // a byte still waiting for fifo room must not be overwritten
            if (shift_wr_i && !push_reg) begin
                shift_reg <= shift_wdata_i;
                drv_bit_reg <= ~shift_wdata_i[7];
            end
            // release by write or release bit, never while a byte is unqueued
            if (hold_reg && !push_reg && (wait_release_i || shift_wr_i)
                    && ms_reg != `IMRSS_M_STOP) begin
                hold_reg <= 1'b0;
            end

            // byte engine, driven by observed clock edges
            if (engine_on && scl_rise) begin
                if (bitcnt_reg < `IMRSS_BIT_ACK) begin
                    shift_reg <= {shift_reg[6:0], sda_lvl};
                end else if (tx_role) begin
                    ack_det_reg <= ~sda_lvl;
                end
                bitcnt_reg <= bitcnt_reg + 4'h1;
            end
            if (engine_on && scl_fall) begin
                if (bitcnt_reg != 4'h0 && bitcnt_reg < `IMRSS_BIT_ACK) begin
                    drv_bit_reg <= ~shift_reg[7];
                end
                if (bitcnt_reg == `IMRSS_BIT_ACK) begin
                    ack_slot_reg <= 1'b1;
                    if (addr_phase_reg) begin
                        dir_rd_reg <= shift_reg[0];
                        match_reg <= ~mst_reg & (shift_reg[7:1] == own_address_i);
                    end else if (mst_reg && dir_rd_reg && !wait_timing_select_i) begin
                        // eighth-clock wait for the receiving master
                        hold_reg <= 1'b1;
                        irq_reg <= 1'b1;
                        cause_reg <= `IMRSS_EV_XFER_END;
                        push_reg <= 1'b1;
                        pushed_reg <= 1'b1;
                    end
                end
                if (bitcnt_reg == `IMRSS_BIT_END) begin
                    ack_slot_reg <= 1'b0;
                    drv_bit_reg <= 1'b0;
                    bitcnt_reg <= 4'h0;
                    addr_phase_reg <= 1'b0;
                    pushed_reg <= 1'b0;
                    if (mst_reg) begin
                        if (addr_phase_reg) begin
                            // raised whether the address was acked or not
                            hold_reg <= 1'b1;
                            irq_reg <= 1'b1;
                            cause_reg <= `IMRSS_EV_ADDR_END;
                        end else if (!dir_rd_reg || wait_timing_select_i) begin
                            hold_reg <= 1'b1;
                            irq_reg <= 1'b1;
                            cause_reg <= `IMRSS_EV_XFER_END;
                            push_reg <= dir_rd_reg & ~pushed_reg;
                        end
                    end else if (addr_phase_reg) begin
                        if (match_reg) begin
                            hold_reg <= 1'b1;
                            irq_reg <= 1'b1;
                            cause_reg <= `IMRSS_EV_ADDR_MATCH;
                            slave_tx_reg <= dir_rd_reg;
                        end else begin
                            sl_act_reg <= 1'b0; // no wait, no event
                        end
                    end else if (slave_tx_reg) begin
                        hold_reg <= 1'b1;
                        irq_reg <= 1'b1;
                        cause_reg <= `IMRSS_EV_XFER_END;
                        if (!ack_det_reg) begin
                            slave_tx_reg <= 1'b0; // NACK ends our sending
                        end
                    end
                end
            end

            // bus conditions override the byte engine
            if (start_det) begin
                busy_reg <= 1'b1;
                addr_phase_reg <= 1'b1;
                bitcnt_reg <= 4'h0;
                ack_slot_reg <= 1'b0;
                match_reg <= 1'b0;
                slave_tx_reg <= 1'b0;
                pushed_reg <= 1'b0;
                mst_reg <= (ms_reg == `IMRSS_M_START);
                sl_act_reg <= (ms_reg != `IMRSS_M_START);
            end
            if (stop_det) begin
                busy_reg <= 1'b0;
                mst_reg <= 1'b0;
                sl_act_reg <= 1'b0;
                slave_tx_reg <= 1'b0;
                ack_slot_reg <= 1'b0;
                hold_reg <= 1'b0;
                match_reg <= 1'b0;
                if (!mst_reg && match_reg) begin
                    irq_reg <= 1'b1;
                    cause_reg <= `IMRSS_EV_STOP;
                end
            end

            // master sequencer: start, clock generation, stop
            case (ms_reg)
                `IMRSS_M_IDLE: begin
                    tmr_reg <= 10'h000;
                    gen_low_reg <= 1'b0;
                    // only a free bus may be claimed
                    if (start_request_i && !busy_reg && scl_lvl && sda_lvl) begin
                        ms_reg <= `IMRSS_M_START;
                    end
                end
                `IMRSS_M_START: begin
                    // count hold time only after our start is seen
                    if (mst_reg) begin
                        tmr_reg <= tmr_reg + 10'h001;
                        if (tmr_reg >= thd_cyc) begin
                            hold_reg <= 1'b1;
                            gen_low_reg <= 1'b1;
                            // data stays low until the address is written, no false stop
                            drv_bit_reg <= 1'b1;
                            tmr_reg <= 10'h000;
                            ms_reg <= `IMRSS_M_RUN;
                        end
                    end
                end
                `IMRSS_M_RUN: begin
                    if (!mst_reg) begin
                        ms_reg <= `IMRSS_M_IDLE;
                    end else if (stop_request_i && hold_reg) begin
                        stop_arm_reg <= 1'b0;
                        ms_reg <= `IMRSS_M_STOP;
                    end else if (hold_reg) begin
                        tmr_reg <= 10'h000;
                    end else if (gen_low_reg) begin
                        tmr_reg <= tmr_reg + 10'h001;
                        if (tmr_reg >= tlow_cyc) begin
                            gen_low_reg <= 1'b0;
                            tmr_reg <= 10'h000;
                        end
                    end else if (scl_lvl) begin
                        // high phase counts only once a stretching slave lets go
                        tmr_reg <= tmr_reg + 10'h001;
                        if (tmr_reg >= thi_cyc) begin
                            gen_low_reg <= 1'b1;
                            tmr_reg <= 10'h000;
                        end
                    end
                end
                `IMRSS_M_STOP: begin
                    if (!stop_arm_reg) begin
                        // data is already low; now let the clock go
                        stop_arm_reg <= 1'b1;
                        hold_reg <= 1'b0;
                        gen_low_reg <= 1'b0;
                        tmr_reg <= 10'h000;
                    end else if (scl_lvl) begin
                        tmr_reg <= tmr_reg + 10'h001;
                        if (tmr_reg >= tsu_cyc) begin
                            ms_reg <= `IMRSS_M_IDLE;
                        end
                    end else begin
                        tmr_reg <= 10'h000;
                    end
                end
                default: begin
                    ms_reg <= `IMRSS_M_IDLE;
                end
            endcase
        end
    end

    // pins are open drain: output value fixed low, enable does the work
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_oe_reg;
    assign sda_oe_o = sda_oe_reg;
    assign shift_rdata_o = shift_reg;
    assign master_status_o = mst_reg;
    assign ack_detected_o = ack_det_reg;
    assign transmit_receive_select_o = tx_reg;
    assign wait_state_o = hold_reg;
    assign bus_busy_o = busy_reg;
    assign transfer_interrupt_o = irq_reg;
    assign int_cause_o = cause_reg;
endmodule // imrss_ctrl

/* shared/imrss_defines.vh */
// constants for the two-wire controller: timing, event codes, fsm states
//
// How it works
// - start request: data low, then clock low
// - own start detected sets master status
// - shift register write sends address byte
// - matching slave acks; master samples 9th rise
// - 9th fall: address-end irq; slave waits, matches
// - mismatched slave: NACK, no irq, no wait
// - address-end irq on both ACK and NACK
// - wait timing select 0 waits after 8th
// - 8th fall: master waits, irq, acks if enabled
// - sending slave samples ack, waits at 9th
// - after final NACK both wait, irq at 9th
// - stop request: data low, await clock high
// - slave stops sending on NACK, still waits at 9th
// - clock high plus setup: data rises, stop irq to addressed slave only
// - start hold at least 4.0/0.6 us
// - stop setup at least 4.0/0.6 us
`ifndef IMRSS_DEFINES_VH
`define IMRSS_DEFINES_VH

`define IMRSS_CLK_NS 10
`define IMRSS_T_HD_STA_STD_NS 4000
`define IMRSS_T_HD_STA_FAST_NS 600
`define IMRSS_T_SU_STO_STD_NS 4000
`define IMRSS_T_SU_STO_FAST_NS 600
`define IMRSS_T_LOW_STD_NS 5000
`define IMRSS_T_LOW_FAST_NS 1300
`define IMRSS_T_HIGH_STD_NS 4000
`define IMRSS_T_HIGH_FAST_NS 600

`define IMRSS_EV_NONE 4'h0
`define IMRSS_EV_ADDR_END 4'h1
`define IMRSS_EV_ADDR_MATCH 4'h2
`define IMRSS_EV_XFER_END 4'h4
`define IMRSS_EV_STOP 4'h8

`define IMRSS_M_IDLE 4'h1
`define IMRSS_M_START 4'h2
`define IMRSS_M_RUN 4'h4
`define IMRSS_M_STOP 4'h8

`define IMRSS_BIT_ACK 4'h8
`define IMRSS_BIT_END 4'h9
`define IMRSS_FIFO_DEPTH 32
`define IMRSS_FIFO_AW 5

`endif

/* design/imrss_pin_sync.v */
// two-flop synchroniser with edge detect for one bus pin
`timescale 1ns/1ps
module imrss_pin_sync (
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire pin_i,
    output wire lvl_o,
    output wire rise_o,
    output wire fall_o
);
    reg meta_reg; // first stage, read only by sync_reg
    reg sync_reg; // safe level
    reg prev_reg; // level one cycle ago

    // idle bus reads high, so reset to one
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else if (ce_i) begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign lvl_o = sync_reg;
    assign rise_o = sync_reg & ~prev_reg;
    assign fall_o = ~sync_reg & prev_reg;
endmodule // imrss_pin_sync

/* design/imrss_fifo.v */
// received-byte fifo with registered output stage
`timescale 1ns/1ps
module imrss_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire in_valid_i,
    input wire [WIDTH-1:0] in_data_i,
    output wire in_ready_o,
    output wire out_valid_o,
    output wire [WIDTH-1:0] out_data_o,
    input wire out_ready_i
);
    localparam [AW:0] FULL_CNT = DEPTH;

    reg [WIDTH-1:0] mem_reg [0:DEPTH-1]; // storage, indexed
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] cnt_reg; // words held in mem_reg
    reg out_valid_reg;
    reg [WIDTH-1:0] out_data_reg;

    wire do_wr = in_valid_i & in_ready_o;
    // prefetch into the output stage whenever it is empty or drained
    wire do_rd = (cnt_reg != {(AW+1){1'b0}}) & (~out_valid_reg | out_ready_i);

    assign in_ready_o = (cnt_reg != FULL_CNT);
    assign out_valid_o = out_valid_reg;
    assign out_data_o = out_data_reg;

    // storage needs no reset; only valid words are ever read
    always @(posedge clk_i) begin
        if (ce_i && do_wr) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // pointers, count and output stage
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
            out_valid_reg <= 1'b0;
            out_data_reg <= {WIDTH{1'b0}};
        end else if (ce_i) begin
            if (do_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
                out_data_reg <= mem_reg[rd_ptr_reg];
                out_valid_reg <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_reg <= 1'b0;
            end
            case ({do_wr, do_rd})
                2'b10: cnt_reg <= cnt_reg + 1'b1;
                2'b01: cnt_reg <= cnt_reg - 1'b1;
                default: cnt_reg <= cnt_reg;
            endcase
        end
    end
endmodule // imrss_fifo

/* bench/imrss_ctrl_chk.sv */
// port checker for the two-wire controller, bound to its top module
`timescale 1ns/1ps
module imrss_ctrl_chk (
    input wire mclk_i,
    input wire rst_n_i,
    input wire scl_i,
    input wire scl_oe_o,
    input wire sda_oe_o,
    input wire start_request_i,
    input wire stop_request_i,
    input wire fast_mode_i,
    input wire master_status_o,
    input wire wait_state_o,
    input wire bus_busy_o,
    input wire sda_i,
    input wire transfer_interrupt_o,
    input wire [3:0] int_cause_o
);
    reg [15:0] hold_reg; // data pulled low while clock free
    reg [15:0] high_reg; // clock wire high span
    wire [15:0] min_cnt = fast_mode_i ? 16'h003c : 16'h0190; // 0.6 us or 4.0 us
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // span counters; wide so that no frame can wrap them
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_reg <= 16'h0000;
            high_reg <= 16'h0000;
        end else begin
            hold_reg <= (scl_oe_o || !sda_oe_o) ? 16'h0000 : hold_reg + 16'h0001;
            high_reg <= (scl_oe_o || !scl_i) ? 16'h0000 : high_reg + 16'h0001;
        end
    end
    property p_start_hold;
        $rose(scl_oe_o) && $past(sda_oe_o) && master_status_o |-> hold_reg >= min_cnt;
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("clock fell too early");
    property p_stop_setup;
        $fell(sda_oe_o) && !scl_oe_o && scl_i && master_status_o |-> high_reg >= min_cnt;
    endproperty
    a_stop_setup: assert property (p_stop_setup) else $error("stop setup too short");
    property p_master_on;
        $rose(master_status_o) |-> sda_oe_o && !scl_oe_o;
    endproperty
    a_master_on: assert property (p_master_on) else $error("master flag without start");
    property p_irq_pulse;
        transfer_interrupt_o |-> $onehot(int_cause_o) ##1 !transfer_interrupt_o;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("bad interrupt pulse");
    property p_wait_scl;
        wait_state_o && $past(wait_state_o) |-> scl_oe_o;
    endproperty
    a_wait_scl: assert property (p_wait_scl) else $error("wait without clock low");
    property p_irq_wait;
        transfer_interrupt_o && !int_cause_o[3] |-> ##[0:3] wait_state_o;
    endproperty
    a_irq_wait: assert property (p_irq_wait) else $error("event without wait");
    property p_stop_req;
        stop_request_i && wait_state_o && master_status_o |-> ##[1:4] sda_oe_o;
    endproperty
    a_stop_req: assert property (p_stop_req) else $error("stop request ignored");
    property p_start_req;
        start_request_i && !bus_busy_o && scl_i && sda_i |-> ##[1:4] sda_oe_o && !scl_oe_o;
    endproperty
    a_start_req: assert property (p_start_req) else $error("start request ignored");
endmodule // imrss_ctrl_chk

bind imrss_ctrl imrss_ctrl_chk imrss_ctrl_chk_inst (.*);

/* bench/imrss_slave_model.sv */
// far-side model: addressed slave that sends counting bytes
`timescale 1ns/1ps
module imrss_slave_model #(
    parameter [6:0] ADDR = 7'h2a // own address of the model
) (
    input wire scl_i,
    input wire sda_i,
    input wire [7:0] base_i,
    output reg sda_oe_o
);
    initial sda_oe_o = 1'b0;
    // one frame per pass; data moves 300 ns after a clock fall to keep hold time
    always begin : frame
        integer i;
        reg [7:0] addr;
        reg [7:0] dat;
        reg nack;
        @(negedge sda_i iff scl_i);
        for (i = 7; i >= 0; i = i - 1) begin
            @(posedge scl_i);
            addr[i] = sda_i;
        end
        @(negedge scl_i) #300;
        // mismatch leaves the line to the pull-up
        if (addr[7:1] == ADDR) begin
            sda_oe_o = 1'b1;
            @(negedge scl_i) #300;
            dat = base_i;
            nack = 1'b0;
            // keep sending until the master answers high
            while (!nack) begin
                for (i = 7; i >= 0; i = i - 1) begin
                    sda_oe_o = ~dat[i];
                    @(negedge scl_i) #300;
                end
                sda_oe_o = 1'b0;
                @(posedge scl_i);
                nack = sda_i;
                @(negedge scl_i) #300;
                dat = dat + 8'h01;
            end
        end
    end
endmodule // imrss_slave_model

/* bench/imrss_ctrl_tb_top.sv */
// testbench: master reads from the slave model through the fifo
`timescale 1ns/1ps
`include "imrss_defines.vh"
module imrss_ctrl_tb_top;
    reg mclk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg ce_i = 1'b1;
    reg fast_mode_i = 1'b1; // fast timings keep the run short
    reg [6:0] own_address_i = 7'h11; // never addressed here
    reg start_request_i = 1'b0;
    reg stop_request_i = 1'b0;
    reg shift_wr_i = 1'b0;
    reg [7:0] shift_wdata_i = 8'h00;
    reg wait_release_i = 1'b0;
    reg wait_timing_select_i = 1'b1;
    reg ack_enable_i = 1'b1;
    reg rx_ready_i = 1'b0; // fifo stalled at first
    wire scl_o, sda_o, scl_oe_o, sda_oe_o, slv_oe;
    wire master_status_o, ack_detected_o, transmit_receive_select_o, wait_state_o;
    wire bus_busy_o, transfer_interrupt_o, rx_valid_o;
    wire [3:0] int_cause_o;
    wire [7:0] shift_rdata_o, rx_data_o;
    wire scl_i = ~scl_oe_o; // pull-up, only the controller drives it
    wire sda_i = ~(sda_oe_o | slv_oe); // wired-and with pull-up
    int mismatches = 0;
    int compares = 0;
    imrss_ctrl imrss_ctrl_inst (.*);
    imrss_slave_model imrss_slave_model_inst (
        .scl_i(scl_i),
        .sda_i(sda_i),
        .base_i(8'h40),
        .sda_oe_o(slv_oe)
    );
    always #5 mclk_i = ~mclk_i;
    task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_sim;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    function logic sig(input int s);
        return s == 0 ? master_status_o : (s == 1 ? wait_state_o : bus_busy_o);
    endfunction
    // bounded poll; a run-out counts as a mismatch
    task automatic wait_st(input int s, input logic v);
        int n = 0;
        while (sig(s) !== v && n < 9000) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 9000) mismatches++;
    endtask
    task automatic wait_irq(input logic [3:0] exp);
        int n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (transfer_interrupt_o !== 1'b1 && n < 9000);
        check("irq", {7'h00, transfer_interrupt_o}, 8'h01);
        check("int_cause", {4'h0, int_cause_o}, {4'h0, exp});
    endtask
    // release pulses only count inside a wait, so wait for it first
    task rel(input logic [7:0] d, input int wr);
        wait_st(1, 1'b1);
        @(posedge mclk_i);
        if (wr) begin
            shift_wdata_i <= d;
            shift_wr_i <= 1'b1;
        end else wait_release_i <= 1'b1;
        @(posedge mclk_i);
        shift_wr_i <= 1'b0;
        wait_release_i <= 1'b0;
    endtask
    task frame_open(input logic [7:0] a, input logic ack);
        @(posedge mclk_i);
        start_request_i <= 1'b1;
        @(posedge mclk_i);
        start_request_i <= 1'b0;
        wait_st(0, 1'b1);
        check("master_status", {7'h00, master_status_o}, 8'h01);
        rel(a, 1);
        check("tx_select", {7'h00, transmit_receive_select_o}, 8'h01);
        wait_irq(`IMRSS_EV_ADDR_END);
        check("ack_detected", {7'h00, ack_detected_o}, {7'h00, ack});
    endtask
    task frame_close;
        wait_st(1, 1'b1);
        @(posedge mclk_i);
        stop_request_i <= 1'b1;
        @(posedge mclk_i);
        stop_request_i <= 1'b0;
        wait_st(2, 1'b0);
        check("master_status", {7'h00, master_status_o}, 8'h00);
    endtask
    initial begin : main
        int k;
        int n;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        // 34 bytes with the consumer stalled: 33 fit, the last must hold the wait
        frame_open({7'h2a, 1'b1}, 1'b1);
        wait_timing_select_i <= 1'b0;
        rel(8'h00, 0);
        for (k = 0; k < 34; k++) begin
            wait_irq(`IMRSS_EV_XFER_END);
            check("shift_rdata", shift_rdata_o, 8'h40 + k[7:0]);
            check("tx_select", {7'h00, transmit_receive_select_o}, 8'h00);
            rel(8'hff, k % 2);
        end
        repeat (20) @(posedge mclk_i);
        check("wait_state", {7'h00, wait_state_o}, 8'h01);
        rx_ready_i <= 1'b1;
        k = 0;
        n = 0;
        while (k < 34 && n < 9000) begin
            @(posedge mclk_i);
            n++;
            if (rx_valid_o === 1'b1) begin
                check("rx_data", rx_data_o, 8'h40 + k[7:0]);
                k++;
            end
        end
        check("rx_count", k[7:0], 8'h22);
        // last byte: answer high and move the wait to the ninth clock
        ack_enable_i <= 1'b0;
        wait_timing_select_i <= 1'b1;
        rel(8'h00, 0);
        wait_irq(`IMRSS_EV_XFER_END);
        frame_close;
        // unknown address: no answer, yet the address-end event still comes
        frame_open({7'h2b, 1'b1}, 1'b0);
        frame_close;
        end_sim;
    end
    initial begin
        #1000000;
        mismatches++;
        end_sim;
    end
endmodule // imrss_ctrl_tb_top
